//--- design/dbmc_top.sv
// Dual full-bridge control: decode, chopping, decay, protection, sleep
`timescale 1ns/1ps
`include "dbmc_cfg.svh"

// Two-flop synchroniser for pin inputs
module dbmc_sync #(parameter int W = 1) (
  input  wire logic         clk,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;

  // First stage feeds only the second; no reset, so true pin levels are in place at release
  always_ff @(posedge clk) begin
    s1_r <= d;
    s2_r <= s1_r;
  end
  assign q = s2_r;
endmodule : dbmc_sync

// One bridge: command drive, chopping with mixed decay, overcurrent retry
module dbmc_bridge import dbmc_pkg::*; #(parameter int RETRY_CYC = `DBMC_RETRY_CYC) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        run,
  input  wire dbmc_cmd_t   cmd,
  input  wire dbmc_sense_t sense,
  output dbmc_gates_t      gates_r,
  output logic             ocp_r
);
  localparam logic [11:0] OFF_C   = 12'(`DBMC_OFF_CYC);
  localparam logic [11:0] FAST_C  = 12'(`DBMC_FAST_CYC);
  localparam logic [11:0] BLANK_C = 12'(`DBMC_BLANK_CYC);
  localparam logic [11:0] DEG_C   = 12'(`DBMC_DEG_CYC);
  localparam logic [18:0] RTY_C   = 19'(RETRY_CYC);

  dbmc_chop_t  st_r, st_nxt;
  logic [11:0] tmr_r, tmr_nxt;
  logic [11:0] deg_r, deg_nxt;
  logic [18:0] rty_r, rty_nxt;
  logic        fwd_r, fwd_nxt;
  logic        nz_r, nz_nxt;
  dbmc_gates_t gates_nxt;
  logic        drive;

  assign drive = (cmd == CMD_FWD) || (cmd == CMD_REV);

  // Chopping sequence and overcurrent filter
  always_comb begin
    st_nxt  = st_r;
    tmr_nxt = tmr_r + 12'h001;
    rty_nxt = rty_r + 19'h00001;
    fwd_nxt = fwd_r;
    nz_nxt  = nz_r;
    deg_nxt = sense.sw_limit ? deg_r + 12'h001 : 12'h000;
    unique case (st_r)
      CH_DRIVE: begin
        if (!drive || !run) begin
          tmr_nxt = 12'h000;
        end else if (tmr_r < BLANK_C) begin
          tmr_nxt = tmr_r + 12'h001;
        end else if (sense.chop_trip) begin
          st_nxt  = CH_FAST;
          tmr_nxt = 12'h000;
          fwd_nxt = (cmd == CMD_FWD);
          nz_nxt  = 1'b0;
        end else begin
          tmr_nxt = tmr_r;
        end
      end
      CH_FAST: begin
        if (sense.near_zero) begin
          nz_nxt = 1'b1;
        end
        if (tmr_r == FAST_C - 12'h001) begin
          st_nxt = CH_SLOW;
        end
      end
      CH_SLOW: begin
        if (tmr_r == OFF_C - 12'h001) begin
          st_nxt  = CH_DRIVE;
          tmr_nxt = 12'h000;
        end
      end
      CH_OCP: begin
        if (rty_r == RTY_C - 19'h00001) begin
          st_nxt  = CH_DRIVE;
          tmr_nxt = 12'h000;
        end
      end
    endcase
    if (st_r != CH_OCP && !run) begin
      st_nxt  = CH_DRIVE;
      tmr_nxt = 12'h000;
    end
    if (st_r != CH_OCP && sense.sw_limit && deg_r == DEG_C - 12'h001) begin
      st_nxt  = CH_OCP;
      rty_nxt = 19'h00000;
      deg_nxt = 12'h000;
    end
  end

  // Switch pattern for the current phase
  always_comb begin
    gates_nxt = '0;
    if (run || st_r == CH_OCP) begin
      unique case (st_r)
        CH_DRIVE: begin
          unique case (cmd)
            CMD_FWD:   gates_nxt = '{hs1: 1'b1, ls1: 1'b0, hs2: 1'b0, ls2: 1'b1};
            CMD_REV:   gates_nxt = '{hs1: 1'b0, ls1: 1'b1, hs2: 1'b1, ls2: 1'b0};
            CMD_BRAKE: gates_nxt = '{hs1: 1'b0, ls1: 1'b1, hs2: 1'b0, ls2: 1'b1};
            CMD_COAST: gates_nxt = '0;
          endcase
        end
        CH_FAST: begin
          if (!nz_r && !sense.near_zero) begin
            gates_nxt = fwd_r ? '{hs1: 1'b0, ls1: 1'b1, hs2: 1'b1, ls2: 1'b0}
                              : '{hs1: 1'b1, ls1: 1'b0, hs2: 1'b0, ls2: 1'b1};
          end
        end
        CH_SLOW: gates_nxt = '{hs1: 1'b0, ls1: 1'b1, hs2: 1'b0, ls2: 1'b1};
        CH_OCP:  gates_nxt = '0;
      endcase
    end
    // Switches go dark on the very edge that takes the overcurrent event
    if (st_nxt == CH_OCP) gates_nxt = '0;
  end

  // Bridge state registers
  always_ff @(posedge clk) begin
    if (rst) begin
      st_r    <= CH_DRIVE;
      tmr_r   <= 12'h000;
      deg_r   <= 12'h000;
      rty_r   <= 19'h00000;
      fwd_r   <= 1'b0;
      nz_r    <= 1'b0;
      gates_r <= '0;
      ocp_r   <= 1'b0;
    end else begin
      st_r    <= st_nxt;
      tmr_r   <= tmr_nxt;
      deg_r   <= deg_nxt;
      rty_r   <= rty_nxt;
      fwd_r   <= fwd_nxt;
      nz_r    <= nz_nxt;
      gates_r <= gates_nxt;
      ocp_r   <= (st_nxt == CH_OCP);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Chopping and protection checks
  a_blank_min: assert property ($rose(st_r == CH_FAST) |-> $past(tmr_r) >= BLANK_C)
    else $error("chop trip taken inside blanking");
  a_fast_quarter: assert property ($rose(st_r == CH_SLOW) |-> $past(tmr_r) == FAST_C - 12'h001)
    else $error("fast decay length wrong");
  a_slow_lows: assert property ((st_r == CH_SLOW && run) |=> gates_r == 4'h5)
    else $error("slow decay not both low sides");
  a_ocp_filter: assert property ($rose(st_r == CH_OCP) |-> $past(deg_r) == DEG_C - 12'h001)
    else $error("overcurrent taken before deglitch");
  a_ocp_dark: assert property ($rose(ocp_r) |-> gates_r == 4'h0 ##1 gates_r == 4'h0)
    else $error("switches on during overcurrent");
  a_retry_len: assert property ($fell(st_r == CH_OCP) |-> $past(rty_r) == RTY_C - 19'h00001)
    else $error("retry interval wrong");
  a_no_shoot: assert property (!(gates_r.hs1 && gates_r.ls1) && !(gates_r.hs2 && gates_r.ls2))
    else $error("shoot-through pattern");
  c_chop: cover property ($rose(st_r == CH_SLOW));
  c_ocp: cover property ($fell(st_r == CH_OCP));
endmodule : dbmc_bridge

// Function
// - Inputs 00 coast, 01 reverse, 10 forward, 11 brake on each bridge.
// - A floating bridge A input outside parallel mode holds its previous outputs.
// - Parallel mode latched when both A inputs float at power-up or wake.
// - In parallel mode the B input pair drives both bridges together.
// - Parallel mode ends only after A inputs are driven at power-up or wake.
// - Chopping threshold reached stops drive for a fixed off-time.
// - Sense comparator ignored for a blanking interval after drive starts.
// - Threshold compares sense voltage against reference divided by 6.6.
// - Off-time is 25% fast decay then 75% slow decay.
// - Fast decay turns on opposite drivers; near-zero current disables the bridge.
// - Slow decay turns on both low-side switches.
// - Persistent switch over-limit past deglitch disables the bridge and pulls fault low.
// - After overcurrent the bridge waits the retry time, then resumes and releases fault.
// - Overcurrent is per bridge, any switch, independent of chopping sense.
// - Over-temperature disables switches, pulls fault; recovery resumes then releases fault.
// - Undervoltage resets all logic and holds fault low until supply recovers.
// - Fault indication is unlatched and clears itself on recovery.
// - Sleep low, after entry delay, disables regulator and floats all outputs.
// - Sleep high wakes the device; outputs follow inputs after a wake delay.
// - Chopping off-time is 20 microseconds.
// - Blanking interval is 1.8 microseconds.
// - Overcurrent deglitch time is 2.8 microseconds.
// - Overcurrent retry interval is 1.6 milliseconds.
module dbmc_top import dbmc_pkg::*; #(parameter int RETRY_CYC = `DBMC_RETRY_CYC) (
  input  wire logic        CORE_CLK,
  input  wire logic        RESET,
  input  wire dbmc_tri_t   BRIDGE_A_CTRL_FIRST,
  input  wire dbmc_tri_t   BRIDGE_A_CTRL_SECOND,
  input  wire logic        BRIDGE_B_CTRL_FIRST,
  input  wire logic        BRIDGE_B_CTRL_SECOND,
  input  wire logic        SLEEP_REQUEST_N,
  input  wire logic        SUPPLY_LOW,
  input  wire logic        OVER_TEMP,
  input  wire dbmc_sense_t BRIDGE_A_SENSE,
  input  wire dbmc_sense_t BRIDGE_B_SENSE,
  output dbmc_gates_t      BRIDGE_A_GATES,
  output dbmc_gates_t      BRIDGE_B_GATES,
  output logic             FAULT_FLAG_N,
  output logic             REGULATOR_EN,
  output logic             PARALLEL_MODE
);
  localparam logic [11:0] SLEEP_C = 12'(`DBMC_SLEEP_CYC);
  localparam logic [11:0] WAKE_C  = 12'(`DBMC_WAKE_CYC);

  logic [14:0] raw, syn;
  dbmc_tri_t   a1_s, a2_s;
  dbmc_sense_t sa_s, sb_s;
  logic        b1_s, b2_s, sl_s, uv_s, ot_s, rst_i, run, wake_evt;
  logic        ocp_a, ocp_b, uv_d_r, ot_d_r;
  dbmc_pwr_t   pw_r, pw_nxt;
  logic [11:0] cnt_r, cnt_nxt;
  dbmc_cmd_t   cmd_b, cmd_a_r, cmd_a_nxt, cmd_bridge_b;
  logic        par_r, par_nxt, por_r;
  logic        fault_nxt, reg_nxt;

  // All pin inputs except RESET pass two flops before use
  assign raw = {BRIDGE_A_CTRL_FIRST, BRIDGE_A_CTRL_SECOND, BRIDGE_B_CTRL_FIRST,
                BRIDGE_B_CTRL_SECOND, SLEEP_REQUEST_N, SUPPLY_LOW, OVER_TEMP,
                BRIDGE_A_SENSE, BRIDGE_B_SENSE};
  dbmc_sync #(.W(15)) u_sync (.clk(CORE_CLK), .d(raw), .q(syn));
  assign {a1_s, a2_s, b1_s, b2_s, sl_s, uv_s, ot_s, sa_s, sb_s} = syn;

  // Undervoltage acts as a reset of all internal logic except the input synchroniser and the fault and regulator output registers
  assign rst_i = RESET | uv_s;

  // Sleep entry and wake sequencing
  always_comb begin
    pw_nxt   = pw_r;
    wake_evt = 1'b0;
    unique case (pw_r)
      PW_WAKING: begin
        if (!sl_s) pw_nxt = PW_ENTER;
        else if (cnt_r == WAKE_C - 12'h001) pw_nxt = PW_AWAKE;
      end
      PW_AWAKE: if (!sl_s) pw_nxt = PW_ENTER;
      PW_ENTER: begin
        if (sl_s) pw_nxt = PW_AWAKE;
        else if (cnt_r == SLEEP_C - 12'h001) pw_nxt = PW_ASLEEP;
      end
      PW_ASLEEP: begin
        if (sl_s) begin
          pw_nxt   = PW_WAKING;
          wake_evt = 1'b1;
        end
      end
    endcase
    cnt_nxt = (pw_nxt != pw_r) ? 12'h000 : cnt_r + 12'h001;
  end

  // Parallel mode latch and bridge A command hold
  assign cmd_b = dbmc_cmd_t'({b1_s, b2_s});
  always_comb begin
    par_nxt = (por_r || wake_evt) ? (a1_s.hiz && a2_s.hiz) : par_r;
    if (par_r) begin
      cmd_a_nxt = cmd_b;
    end else if (a1_s.hiz || a2_s.hiz) begin
      cmd_a_nxt = cmd_a_r;
    end else begin
      cmd_a_nxt = dbmc_cmd_t'({a1_s.lvl, a2_s.lvl});
    end
  end
  assign cmd_bridge_b = cmd_b;

  // Bridges run only when awake and cool
  assign run = (pw_r == PW_AWAKE || pw_r == PW_ENTER) && !ot_s;

  // Unlatched fault and regulator enable
  assign fault_nxt = !(uv_s || uv_d_r || ot_s || ot_d_r || ocp_a || ocp_b);
  assign reg_nxt   = (pw_r != PW_ASLEEP) && !uv_s;

  // Internal state, cleared by undervoltage too
  always_ff @(posedge CORE_CLK) begin
    if (rst_i) begin
      pw_r    <= PW_WAKING;
      cnt_r   <= 12'h000;
      par_r   <= 1'b0;
      por_r   <= 1'b1;
      cmd_a_r <= CMD_COAST;
    end else begin
      pw_r    <= pw_nxt;
      cnt_r   <= cnt_nxt;
      par_r   <= par_nxt;
      por_r   <= 1'b0;
      cmd_a_r <= cmd_a_nxt;
    end
  end

  // Fault and regulator outputs, kept alive through undervoltage
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      uv_d_r       <= 1'b0;
      ot_d_r       <= 1'b0;
      FAULT_FLAG_N <= 1'b1;
      REGULATOR_EN <= 1'b0;
    end else begin
      uv_d_r       <= uv_s;
      ot_d_r       <= ot_s;
      FAULT_FLAG_N <= fault_nxt;
      REGULATOR_EN <= reg_nxt;
    end
  end
  assign PARALLEL_MODE = par_r;

  dbmc_bridge #(.RETRY_CYC(RETRY_CYC)) u_br_a (.clk(CORE_CLK), .rst(rst_i), .run(run),
    .cmd(cmd_a_r), .sense(sa_s), .gates_r(BRIDGE_A_GATES), .ocp_r(ocp_a));
  dbmc_bridge #(.RETRY_CYC(RETRY_CYC)) u_br_b (.clk(CORE_CLK), .rst(rst_i), .run(run),
    .cmd(cmd_bridge_b), .sense(sb_s), .gates_r(BRIDGE_B_GATES), .ocp_r(ocp_b));

  default clocking tb_cb @(posedge CORE_CLK); endclocking
  default disable iff (RESET);

  // Device level checks
  a_uv_fault: assert property (uv_s |=> !FAULT_FLAG_N)
    else $error("fault not low in undervoltage");
  a_sleep_dark: assert property ((pw_r == PW_ASLEEP && !uv_s) |=>
      (BRIDGE_A_GATES == 4'h0 && BRIDGE_B_GATES == 4'h0 && !REGULATOR_EN))
    else $error("outputs active in sleep");
  a_hold_a: assert property ((!rst_i && !par_r && (a1_s.hiz || a2_s.hiz))
      |=> cmd_a_r == $past(cmd_a_r))
    else $error("bridge A command not held");
  a_par_steady: assert property ((!rst_i && !por_r && !wake_evt) |=> $stable(PARALLEL_MODE))
    else $error("parallel mode changed outside wake");
  c_par: cover property ($rose(PARALLEL_MODE));
  c_wake: cover property (pw_r == PW_ASLEEP ##1 pw_r == PW_WAKING);
endmodule : dbmc_top

//--- design/dbmc_cfg.svh
// Timing constants for the dual bridge motor control block
`ifndef DBMC_CFG_SVH
`define DBMC_CFG_SVH

// Reference clock period, 200 MHz
`define DBMC_CLK_NS 5

// Interval figures in nanoseconds
`define DBMC_OFF_NS 20000
`define DBMC_BLANK_NS 1800
`define DBMC_DEG_NS 2800
`define DBMC_RETRY_NS 1600000
`define DBMC_SLEEP_NS 1000
`define DBMC_WAKE_NS 1000

// Least times round up to whole clock cycles
`define DBMC_CEIL_CYC(ns) (((ns) + `DBMC_CLK_NS - 1) / `DBMC_CLK_NS)
`define DBMC_OFF_CYC `DBMC_CEIL_CYC(`DBMC_OFF_NS)
`define DBMC_FAST_CYC (`DBMC_OFF_CYC / 4)
`define DBMC_BLANK_CYC `DBMC_CEIL_CYC(`DBMC_BLANK_NS)
`define DBMC_DEG_CYC `DBMC_CEIL_CYC(`DBMC_DEG_NS)
`define DBMC_RETRY_CYC `DBMC_CEIL_CYC(`DBMC_RETRY_NS)
`define DBMC_SLEEP_CYC `DBMC_CEIL_CYC(`DBMC_SLEEP_NS)
`define DBMC_WAKE_CYC `DBMC_CEIL_CYC(`DBMC_WAKE_NS)

`endif

//--- design/dbmc_pkg.sv
// Types shared by the dual bridge motor control block
package dbmc_pkg;
  typedef enum logic [1:0] {CMD_COAST, CMD_REV, CMD_FWD, CMD_BRAKE} dbmc_cmd_t;
  typedef enum logic [1:0] {CH_DRIVE, CH_FAST, CH_SLOW, CH_OCP} dbmc_chop_t;
  typedef enum logic [1:0] {PW_WAKING, PW_AWAKE, PW_ENTER, PW_ASLEEP} dbmc_pwr_t;
  typedef struct packed {logic hiz; logic lvl;} dbmc_tri_t;
  typedef struct packed {logic hs1; logic ls1; logic hs2; logic ls2;} dbmc_gates_t;
  typedef struct packed {logic chop_trip; logic near_zero; logic sw_limit;} dbmc_sense_t;
endpackage : dbmc_pkg

//--- tb/dbmc_ctrl_model.sv
// Motion controller model that drives the bridge pins and the sleep request
`timescale 1ns/1ps
module dbmc_ctrl_model import dbmc_pkg::*; (
  input  wire logic      clk,
  input  wire dbmc_cmd_t cmd_a,
  input  wire logic      float_a,
  input  wire dbmc_cmd_t cmd_b,
  input  wire logic      wake_req,
  output dbmc_tri_t      a_first,
  output dbmc_tri_t      a_second,
  output logic           b_first,
  output logic           b_second,
  output logic           sleep_n
);
  logic tog_r = 1'b0;

  // Pins move just after the edge; a floated pin carries a level that flips each cycle
  always_ff @(posedge clk) begin
    tog_r    <= ~tog_r;
    a_first  <= float_a ? {1'b1, tog_r} : {1'b0, cmd_a[1]};
    a_second <= float_a ? {1'b1, ~tog_r} : {1'b0, cmd_a[0]};
    b_first  <= cmd_b[1];
    b_second <= cmd_b[0];
    sleep_n  <= wake_req;
  end
endmodule : dbmc_ctrl_model

//--- tb/dbmc_top_tb.sv
// Self-checking bench for the dual bridge control block
`timescale 1ns/1ps
module dbmc_top_tb import dbmc_pkg::*; ;
  localparam int RETRY = 50;
  localparam int SA = 0;
  localparam int SB = 1;
  localparam int SF = 2;
  localparam int SR = 3;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  dbmc_cmd_t   cmd_a = CMD_COAST;
  dbmc_cmd_t   cmd_b = CMD_COAST;
  logic        float_a = 1'b0;
  logic        wake_req = 1'b1;
  logic        supply_low = 1'b0;
  logic        over_temp = 1'b0;
  dbmc_sense_t sense_a = '0;
  dbmc_sense_t sense_b = '0;
  dbmc_tri_t   a_first;
  dbmc_tri_t   a_second;
  logic        b_first;
  logic        b_second;
  logic        sleep_n;
  dbmc_gates_t gates_a;
  dbmc_gates_t gates_b;
  logic        fault_n;
  logic        reg_en;
  logic        par_mode;
  int          miscompares = 0;
  int          cmp_count = 0;
  logic [31:0] seed = 32'h000140d2;

  // 200 MHz core clock
  always #2.5 clk = ~clk;

  dbmc_ctrl_model dbmc_ctrl_model_inst (.clk(clk), .cmd_a(cmd_a), .float_a(float_a),
    .cmd_b(cmd_b), .wake_req(wake_req), .a_first(a_first), .a_second(a_second),
    .b_first(b_first), .b_second(b_second), .sleep_n(sleep_n));

  dbmc_top #(.RETRY_CYC(RETRY)) dbmc_top_inst (.CORE_CLK(clk), .RESET(rst),
    .BRIDGE_A_CTRL_FIRST(a_first), .BRIDGE_A_CTRL_SECOND(a_second),
    .BRIDGE_B_CTRL_FIRST(b_first), .BRIDGE_B_CTRL_SECOND(b_second),
    .SLEEP_REQUEST_N(sleep_n), .SUPPLY_LOW(supply_low), .OVER_TEMP(over_temp),
    .BRIDGE_A_SENSE(sense_a), .BRIDGE_B_SENSE(sense_b), .BRIDGE_A_GATES(gates_a),
    .BRIDGE_B_GATES(gates_b), .FAULT_FLAG_N(fault_n), .REGULATOR_EN(reg_en),
    .PARALLEL_MODE(par_mode));

  // Switch pattern that a bridge command should produce
  function automatic logic [3:0] exp_gates(input dbmc_cmd_t c);
    case (c)
      CMD_REV:   return 4'h6;
      CMD_FWD:   return 4'h9;
      CMD_BRAKE: return 4'h5;
      default:   return 4'h0;
    endcase
  endfunction : exp_gates

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xorshift

  // Observed output picked by selector
  function automatic logic [3:0] probe(input int s);
    case (s)
      SA:      return gates_a;
      SB:      return gates_b;
      SF:      return {3'h0, fault_n};
      default: return {3'h0, reg_en};
    endcase
  endfunction : probe

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report

  task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic chk_rng(input string what, input int lo, input int hi, input int got);
    cmp_count++;
    if (got < lo || got > hi) begin
      miscompares++;
      $display("wrong value %s expected %0d to %0d seen %0d", what, lo, hi, got);
    end
  endtask : chk_rng

  // Sample point sits just after the edge so the design's updates have landed
  task automatic ticks(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : ticks

  // Bounded wait for an output value; n returns the cycles taken
  task automatic wait_for(input string what, input int s, input logic [3:0] v,
                          input int lim, output int n);
    n = 0;
    while (probe(s) !== v && n < lim) begin
      ticks(1);
      n++;
    end
    chk(what, v, probe(s));
    if (probe(s) !== v) final_report();
  endtask : wait_for

  initial begin : main
    int n;
    dbmc_cmd_t prev_a;
    prev_a = CMD_COAST;
    cmd_b <= CMD_FWD;
    ticks(5);
    rst <= 1'b0;
    wait_for("wake b", SB, 4'h9, 300, n);
    chk_rng("wake delay", 198, 212, n);
    // Random commands on both bridges, with bridge A floated now and then
    for (int i = 0; i < 24; i++) begin
      seed = xorshift(seed);
      cmd_a <= dbmc_cmd_t'(seed[1:0]);
      cmd_b <= dbmc_cmd_t'(seed[3:2]);
      float_a <= (i > 0) && seed[4] && seed[5];
      ticks(8);
      if (!float_a) prev_a = cmd_a;
      chk("gates a", exp_gates(prev_a), gates_a);
      chk("gates b", exp_gates(cmd_b), gates_b);
    end
    // Chopping on bridge B with the comparator tripped from the start
    float_a <= 1'b0;
    cmd_a <= CMD_FWD;
    cmd_b <= CMD_COAST;
    ticks(8);
    sense_b.chop_trip <= 1'b1;
    cmd_b <= CMD_FWD;
    wait_for("drive", SB, 4'h9, 8, n);
    wait_for("fast decay", SB, 4'h6, 400, n);
    chk_rng("blanking", 356, 366, n);
    wait_for("slow decay", SB, 4'h5, 1010, n);
    chk_rng("fast part", 995, 1005, n);
    wait_for("redrive", SB, 4'h9, 3010, n);
    chk_rng("slow part", 2995, 3005, n);
    wait_for("fast again", SB, 4'h6, 400, n);
    sense_b.near_zero <= 1'b1;
    sense_b.chop_trip <= 1'b0;
    wait_for("near zero off", SB, 4'h0, 6, n);
    sense_b.near_zero <= 1'b0;
    wait_for("slow after zero", SB, 4'h5, 1010, n);
    wait_for("drive resumes", SB, 4'h9, 3010, n);
    ticks(500);
    chk("no trip", 4'h9, gates_b);
    // Overcurrent on bridge A only
    sense_a.sw_limit <= 1'b1;
    wait_for("ocp off", SA, 4'h0, 600, n);
    chk_rng("deglitch", 558, 568, n);
    wait_for("ocp fault", SF, 4'h0, 4, n);
    chk("b unaffected", 4'h9, gates_b);
    sense_a.sw_limit <= 1'b0;
    wait_for("retry", SA, 4'h9, RETRY + 10, n);
    chk_rng("retry time", RETRY - 8, RETRY + 2, n);
    wait_for("ocp release", SF, 4'h1, 4, n);
    // Over-temperature shuts both bridges and recovers unaided
    over_temp <= 1'b1;
    wait_for("hot off", SB, 4'h0, 6, n);
    wait_for("hot fault", SF, 4'h0, 4, n);
    chk("hot a off", 4'h0, gates_a);
    over_temp <= 1'b0;
    wait_for("cool drive", SB, 4'h9, 6, n);
    wait_for("hot release", SF, 4'h1, 4, n);
    // Supply undervoltage resets the logic
    supply_low <= 1'b1;
    wait_for("uv fault", SF, 4'h0, 5, n);
    ticks(3);
    chk("uv gates", 4'h0, gates_b);
    supply_low <= 1'b0;
    wait_for("uv recover", SB, 4'h9, 300, n);
    wait_for("uv release", SF, 4'h1, 4, n);
    // Sleep with A floated, then wake into parallel mode
    float_a <= 1'b1;
    wake_req <= 1'b0;
    wait_for("sleep reg", SR, 4'h0, 215, n);
    chk_rng("sleep delay", 198, 208, n);
    chk("sleep gates a", 4'h0, gates_a);
    chk("sleep gates b", 4'h0, gates_b);
    wake_req <= 1'b1;
    wait_for("wake reg", SR, 4'h1, 5, n);
    wait_for("wake drive", SB, 4'h9, 215, n);
    chk("parallel on", 4'h1, {3'h0, par_mode});
    chk("paired a", 4'h9, gates_a);
    cmd_b <= CMD_REV;
    cmd_a <= CMD_BRAKE;
    float_a <= 1'b0;
    ticks(8);
    chk("pair follows b", 4'h6, gates_a);
    chk("parallel held", 4'h1, {3'h0, par_mode});
    wake_req <= 1'b0;
    ticks(220);
    wake_req <= 1'b1;
    wait_for("wake again", SB, 4'h6, 215, n);
    chk("parallel off", 4'h0, {3'h0, par_mode});
    chk("a own cmd", 4'h5, gates_a);
    // Sleep request dropped before the entry delay ends keeps the bridges running
    wake_req <= 1'b0;
    ticks(20);
    wake_req <= 1'b1;
    ticks(8);
    chk("sleep abort", 4'h6, gates_b);
    chk("abort reg", 4'h1, {3'h0, reg_en});
    final_report();
  end
endmodule : dbmc_top_tb
